// *** design/fan_pkg.sv ***
// constants shared by the fan drive supervisor
// assumes a 250 MHz core clock and 16-bit stored configuration words
package fan_pkg;
  localparam int CLK_MHZ = 250;
  localparam int CLK_PERIOD_NS = 4;
  // stored word indices
  localparam logic [4:0] W_CUSTOMER = 5'h04;
  localparam logic [4:0] W_SPARE = 5'h06;
  localparam logic [4:0] W_LOCK_KEY = 5'h07;
  localparam logic [4:0] W_DUTY_CFG = 5'h08;
  localparam logic [4:0] W_START_CFG = 5'h09;
  localparam logic [4:0] W_COAST_CFG = 5'h0a;
  localparam logic [4:0] W_LOCK_TIME = 5'h0f;
  localparam logic [4:0] W_MOTOR_CFG = 5'h12;
  localparam logic [4:0] W_PROT_CFG = 5'h13;
  localparam logic [4:0] W_HOST_CFG = 5'h14;
  localparam logic [4:0] W_STATUS = 5'h18;
  localparam int NVM_DEPTH = 24;
  // field positions
  localparam int MAXCLP_LSB = 0;
  localparam int MINCLP_LSB = 4;
  localparam int CUTLVL_LSB = 10;
  localparam int CUTHYS_LSB = 14;
  localparam int TLOCK_LSB = 8;
  localparam int SPDSEL_BIT = 3;
  localparam int PP_LSB = 4;
  localparam int OVHOLD_BIT = 9;
  localparam int SLEW_BIT = 10;
  localparam int SHORTCLR_BIT = 15;
  localparam int STBYINH_BIT = 0;
  localparam int OVINH_BIT = 13;
  localparam int OVLVL_BIT = 14;
  localparam int RANGE_BIT = 15;
  localparam int HOSTEN_BIT = 9;
  localparam int RETRY_LSB = 10;
  localparam int RETRYEN_BIT = 14;
  // stored defaults
  localparam logic [15:0] DEF_START_CFG = 16'hde26;
  localparam logic [15:0] DEF_COAST_CFG = 16'h3b1e;
  localparam logic [15:0] DEF_LOCK_TIME = 16'h3218;
  localparam logic [15:0] DEF_MOTOR_CFG = 16'h5294;
  localparam logic [15:0] DEF_PROT_CFG = 16'h0001;
  // duty arithmetic, 9-bit full scale
  localparam logic [9:0] DUTY_FULL = 10'h1ff;
  localparam logic [9:0] ADC_OFFSET = 10'h002;
  localparam logic [9:0] STEP_COARSE = 10'h008;
  localparam logic [9:0] STEP_FINE = 10'h004;
  localparam logic [7:0] TLOCK_LATCHOFF = 8'hff;
  localparam logic [15:0] READ_BLOCKED = 16'h0000;
  // timing
  localparam int LOCK_LSB_MS = 100;
  localparam int LOCK_LSB_CYC = LOCK_LSB_MS * 1000 * CLK_MHZ;
  localparam int SPD_WIN_MS = 100;
  localparam int SPD_SAMPLES = 511;
  localparam int SPD_SAMPLE_CYC = SPD_WIN_MS * 1000 * CLK_MHZ / SPD_SAMPLES;
  localparam int SHORT_BLANK_NS = 500;
  localparam int SHORT_BLANK_CYC = (SHORT_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEW_FAST_NS = 100;
  localparam int SLEW_SLOW_NS = 150;
  localparam logic [6:0] DEV_ADDR_DEF = 7'h2a;
  typedef enum logic [2:0] {M_OFF, M_START, M_RUN, M_LOCKOUT, M_LATCHED, M_STANDBY} motor_e;
  typedef enum logic [2:0] {I_IDLE, I_DEV, I_PTR, I_WDAT, I_RDAT} i2c_e;
endpackage

// *** design/fan_drive_supervisor.sv ***
// control and protection logic of a sensorless three-phase fan driver
// assumes commutation, modulator and analog comparators live outside;
// shared pins are open drain, resolved by the surrounding pad logic
`timescale 1ns/1ns
module fan_drive_supervisor
  import fan_pkg::*;
#(
  parameter int LOCK_CYC = LOCK_LSB_CYC,
  parameter int SAMPLE_CYC = SPD_SAMPLE_CYC,
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF // arbitrary value
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // shared pins: demand / serial clock, tach / serial data
  input wire logic speed_demand_in,
  input wire logic tach_pin_in,
  output logic tach_out,
  output logic tach_oe,
  // comparator levels from the analog side (asynchronous)
  input wire logic main_supply_uv,
  input wire logic supply_over_protect_in,
  input wire logic thermal_trip,
  input wire logic pump_rail_uv,
  input wire logic short_protect_in,
  input wire logic current_limit,
  // same-clock inputs from converter, commutation and modulator
  input wire logic [8:0] adc_code,
  input wire logic rotor_lock,
  input wire logic comm_quarter,
  input wire logic open_loop_done,
  input wire logic pwm_raw,
  // drive controls
  output logic pwm_gate,
  output logic drive_enable,
  output logic startup_req,
  output logic [8:0] applied_duty,
  output logic [8:0] startup_demand,
  output logic slew_slow,
  output logic overvolt_level_sel,
  output logic supply_range_sel,
  output logic pump_enable,
  output logic vref_enable,
  // status pins
  output logic startup_ok_out,
  output logic startup_ok_oe,
  output logic fault_flag_low
);
  if (LOCK_CYC < 1 || SAMPLE_CYC < 1) begin : g_chk
    $error("timing counts must be at least one cycle");
  end

  function automatic logic writable(input logic [4:0] a);
    writable = (a == W_CUSTOMER) || (a == W_SPARE) || (a >= W_LOCK_KEY && a < 5'(NVM_DEPTH));
  endfunction

  // synchronisers: stage one feeds stage two only
  logic [7:0] async_in, sync1_r, sync2_r;
  assign async_in = {speed_demand_in, tach_pin_in, main_supply_uv, supply_over_protect_in,
                     thermal_trip, pump_rail_uv, short_protect_in, current_limit};
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // both shared pins idle high; resetting there keeps a false clock edge away
      sync1_r <= 8'hc0;
      sync2_r <= 8'hc0;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end
  logic spd_s, sda_s, uv_s, ov_s, tsd_s, puv_s, short_s, ocl_s;
  assign {spd_s, sda_s, uv_s, ov_s, tsd_s, puv_s, short_s, ocl_s} = sync2_r;

  // stored words; contents survive reset, as nonvolatile storage does
  logic [15:0] nvm [NVM_DEPTH];
  initial begin
    for (int i = 0; i < NVM_DEPTH; i++) nvm[i] = '0;
    nvm[W_START_CFG] = DEF_START_CFG;
    nvm[W_COAST_CFG] = DEF_COAST_CFG;
    nvm[W_LOCK_TIME] = DEF_LOCK_TIME;
    nvm[W_MOTOR_CFG] = DEF_MOTOR_CFG;
    nvm[W_PROT_CFG] = DEF_PROT_CFG;
  end
  logic wr_en_r;
  logic [4:0] wr_addr_r;
  logic [15:0] wr_data_r;
  // plain always: the power-up contents above also write this array
  always @(posedge mclk) begin
    if (wr_en_r && writable(wr_addr_r)) nvm[wr_addr_r] <= wr_data_r;
  end

  logic [15:0] duty_cfg, motor_cfg, prot_cfg, host_cfg;
  logic [7:0] tlock;
  assign duty_cfg = nvm[W_DUTY_CFG];
  assign motor_cfg = nvm[W_MOTOR_CFG];
  assign prot_cfg = nvm[W_PROT_CFG];
  assign host_cfg = nvm[W_HOST_CFG];
  assign tlock = nvm[W_LOCK_TIME][TLOCK_LSB +: 8];

  // key captured once after reset release: a new key acts only after the next reset
  logic armed_r, protect_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      armed_r <= 1'b0;
      protect_r <= 1'b0;
    end else if (!armed_r) begin
      armed_r <= 1'b1;
      protect_r <= |nvm[W_LOCK_KEY];
    end
  end

  // serial slave on the shared pins
  logic scl_d_r, sda_d_r;
  i2c_e iph_r;
  logic [3:0] bit_r;
  logic [7:0] rx_r;
  logic [15:0] tx_r;
  logic [7:0] hi_r;
  logic [4:0] ptr_r;
  logic lo_r, rw_r, sda_low_r;
  logic [15:0] status_w, rd_word;
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = spd_s && !scl_d_r;
  assign scl_fall = !spd_s && scl_d_r;
  assign start_c = spd_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_c = spd_s && scl_d_r && !sda_d_r && sda_s;
  always_comb begin
    if (ptr_r == W_STATUS) rd_word = status_w;
    else if (ptr_r >= 5'(NVM_DEPTH) || !writable(ptr_r) || protect_r) rd_word = READ_BLOCKED;
    else rd_word = nvm[ptr_r];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      iph_r <= I_IDLE;
      bit_r <= '0;
      rx_r <= '0;
      tx_r <= '0;
      hi_r <= '0;
      ptr_r <= '0;
      lo_r <= 1'b0;
      rw_r <= 1'b0;
      sda_low_r <= 1'b0;
      wr_en_r <= 1'b0;
      wr_addr_r <= '0;
      wr_data_r <= '0;
    end else begin
      scl_d_r <= spd_s;
      sda_d_r <= sda_s;
      wr_en_r <= 1'b0;
      if (start_c) begin
        iph_r <= I_DEV;
        // the start's own clock fall wraps the count to zero
        bit_r <= 4'hf;
        sda_low_r <= 1'b0;
      end else if (stop_c) begin
        iph_r <= I_IDLE;
        sda_low_r <= 1'b0;
      end else if (iph_r != I_IDLE) begin
        if (scl_rise && bit_r < 4'd8 && iph_r != I_RDAT) rx_r <= {rx_r[6:0], sda_s};
        if (scl_rise && bit_r == 4'd8 && iph_r == I_RDAT && sda_s) iph_r <= I_IDLE;
        if (scl_fall) begin
          if (bit_r == 4'd7) begin
            bit_r <= 4'd8;
            sda_low_r <= 1'b0;
            case (iph_r)
              I_DEV: begin
                if (rx_r[7:1] == DEV_ADDR) begin
                  sda_low_r <= 1'b1;
                  rw_r <= rx_r[0];
                end else begin
                  iph_r <= I_IDLE;
                end
              end
              I_PTR: begin
                ptr_r <= rx_r[4:0];
                lo_r <= 1'b0;
                sda_low_r <= 1'b1;
              end
              I_WDAT: begin
                sda_low_r <= 1'b1;
                lo_r <= !lo_r;
                if (!lo_r) begin
                  hi_r <= rx_r;
                end else begin
                  wr_en_r <= 1'b1;
                  wr_addr_r <= ptr_r;
                  wr_data_r <= {hi_r, rx_r};
                  ptr_r <= ptr_r + 5'd1;
                end
              end
              default: ;
            endcase
          end else if (bit_r == 4'd8) begin
            bit_r <= '0;
            sda_low_r <= 1'b0;
            case (iph_r)
              I_DEV: begin
                if (rw_r) begin
                  iph_r <= I_RDAT;
                  lo_r <= 1'b0;
                  sda_low_r <= !rd_word[15];
                  tx_r <= {rd_word[14:0], 1'b0};
                end else begin
                  iph_r <= I_PTR;
                end
              end
              I_PTR: iph_r <= I_WDAT;
              I_RDAT: begin
                lo_r <= !lo_r;
                if (!lo_r) begin
                  sda_low_r <= !tx_r[15];
                  tx_r <= {tx_r[14:0], 1'b0};
                end else begin
                  ptr_r <= ptr_r + 5'd1;
                  sda_low_r <= !nvm_next_bit(ptr_r + 5'd1);
                  tx_r <= '0;
                  iph_r <= I_DEV;
                  rw_r <= 1'b1;
                  bit_r <= 4'd8;
                end
              end
              default: ;
            endcase
          end else begin
            bit_r <= bit_r + 4'd1;
            if (iph_r == I_RDAT) begin
              sda_low_r <= !tx_r[15];
              tx_r <= {tx_r[14:0], 1'b0};
            end
          end
        end
      end
    end
  end

  // next-word streaming restarts the read path through the device-ack branch;
  // the first bit is reloaded there, so this only keeps the line released meanwhile
  function automatic logic nvm_next_bit(input logic [4:0] a);
    nvm_next_bit = 1'b1;
  endfunction

  // demand measurement: 511 samples over a fixed window give a 9-bit duty code
  logic [31:0] samp_r;
  logic [8:0] win_r, hicnt_r, duty_pwm_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      samp_r <= '0;
      win_r <= '0;
      hicnt_r <= '0;
      duty_pwm_r <= '0;
    end else if (samp_r == 32'(SAMPLE_CYC - 1)) begin
      samp_r <= '0;
      if (win_r == 9'(SPD_SAMPLES - 1)) begin
        win_r <= '0;
        hicnt_r <= '0;
        duty_pwm_r <= hicnt_r + {8'h00, spd_s};
      end else begin
        win_r <= win_r + 9'd1;
        hicnt_r <= hicnt_r + {8'h00, spd_s};
      end
    end else begin
      samp_r <= samp_r + 32'd1;
    end
  end

  logic [9:0] adc_sum, dmd, cut_th, cut_rel, clamp_hi, clamp_lo;
  logic [3:0] cut_code;
  always_comb begin
    adc_sum = {1'b0, adc_code} + ADC_OFFSET;
    if (adc_sum > DUTY_FULL) adc_sum = DUTY_FULL;
    if (host_cfg[HOSTEN_BIT]) dmd = {1'b0, host_cfg[8:0]};
    else if (motor_cfg[SPDSEL_BIT]) dmd = adc_sum;
    else dmd = {1'b0, duty_pwm_r};
    cut_code = duty_cfg[CUTLVL_LSB +: 4];
    cut_th = DUTY_FULL - 10'((cut_code - 4'd1) * STEP_COARSE);
    cut_rel = cut_th - 10'((duty_cfg[CUTHYS_LSB +: 2] + 2'd0 + 10'd1) * STEP_FINE);
    clamp_hi = DUTY_FULL - 10'(duty_cfg[MAXCLP_LSB +: 4] * STEP_COARSE);
    clamp_lo = 10'(duty_cfg[MINCLP_LSB +: 6] * STEP_FINE);
  end

  logic cut_r, dmd_on;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) cut_r <= 1'b0;
    else if (cut_code == 4'd0) cut_r <= 1'b0;
    else if (dmd >= cut_th) cut_r <= 1'b1;
    else if (dmd < cut_rel) cut_r <= 1'b0;
  end
  assign dmd_on = (dmd != 10'd0) && !cut_r;

  // protection levels
  logic ov_hold, ov_inh, ov_block, hold_block, short_trip, lsb_tick;
  assign ov_hold = motor_cfg[OVHOLD_BIT];
  assign ov_inh = prot_cfg[OVINH_BIT];
  assign ov_block = ov_s && !ov_hold;
  assign hold_block = uv_s || puv_s || ov_block;

  logic [31:0] lsb_r;
  logic [7:0] lock_units_r, low_units_r;
  logic [15:0] blank_r;
  motor_e st_r;
  logic [3:0] evt_cnt_r;
  logic running;
  assign running = (st_r == M_START) || (st_r == M_RUN);
  assign lsb_tick = lsb_r == 32'(LOCK_CYC - 1);
  assign short_trip = blank_r == 16'(SHORT_BLANK_CYC);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) lsb_r <= '0;
    else lsb_r <= lsb_tick ? 32'd0 : lsb_r + 32'd1;
  end

  // short is only watched while an output conducts
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) blank_r <= '0;
    else if (!(short_s && drive_enable)) blank_r <= '0;
    else if (!short_trip) blank_r <= blank_r + 16'd1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) low_units_r <= '0;
    else if (spd_s) low_units_r <= '0;
    else if (lsb_tick && low_units_r != 8'hff) low_units_r <= low_units_r + 8'd1;
  end

  // one event source at a time; a locked rotor and a trip in one cycle count once
  logic evt, to_latch;
  logic [3:0] cnt_nxt;
  assign evt = running && (rotor_lock || tsd_s || (ov_s && ov_hold && !ov_inh) || short_trip);
  assign cnt_nxt = (evt_cnt_r == 4'hf) ? evt_cnt_r : evt_cnt_r + 4'd1;
  assign to_latch = (short_trip && motor_cfg[SHORTCLR_BIT]) || (tlock == TLOCK_LATCHOFF) ||
                    (host_cfg[RETRYEN_BIT] && cnt_nxt > host_cfg[RETRY_LSB +: 4]);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= M_OFF;
      evt_cnt_r <= '0;
      lock_units_r <= '0;
      startup_req <= 1'b0;
    end else begin
      startup_req <= 1'b0;
      if (lsb_tick && lock_units_r != 8'hff) lock_units_r <= lock_units_r + 8'd1;
      case (st_r)
        M_OFF: begin
          if (!prot_cfg[STBYINH_BIT] && low_units_r >= tlock) st_r <= M_STANDBY;
          else if (dmd_on && !hold_block) begin
            st_r <= M_START;
            startup_req <= 1'b1;
          end
        end
        M_START, M_RUN: begin
          if (evt) begin
            evt_cnt_r <= host_cfg[RETRYEN_BIT] ? cnt_nxt : evt_cnt_r;
            lock_units_r <= '0;
            st_r <= to_latch ? M_LATCHED : M_LOCKOUT;
          end else if (!dmd_on) begin
            st_r <= M_OFF;
          end else if (st_r == M_START && open_loop_done) begin
            st_r <= M_RUN;
          end
        end
        M_LOCKOUT: begin
          // strictly above: the first tick may follow at once, so one more keeps the full time
          if (lock_units_r > tlock && !tsd_s && !ov_s) st_r <= M_OFF;
        end
        M_LATCHED: begin
          if (!dmd_on) begin
            st_r <= M_OFF;
            evt_cnt_r <= '0;
          end
        end
        M_STANDBY: begin
          if (spd_s) st_r <= M_OFF;
        end
        default: st_r <= M_OFF;
      endcase
    end
  end

  // current limit chops the pulse until the modulator ends it
  logic ocl_hold_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ocl_hold_r <= 1'b0;
      pwm_gate <= 1'b0;
      drive_enable <= 1'b0;
    end else begin
      if (!pwm_raw) ocl_hold_r <= 1'b0;
      else if (ocl_s) ocl_hold_r <= 1'b1;
      drive_enable <= running && !hold_block && !evt;
      pwm_gate <= pwm_raw && !ocl_hold_r && !ocl_s && running && !hold_block;
    end
  end

  logic [9:0] duty_lim;
  always_comb begin
    duty_lim = dmd;
    if (duty_lim > clamp_hi) duty_lim = clamp_hi;
    if (duty_lim < clamp_lo) duty_lim = clamp_lo;
  end

  // tach: toggle every pole-pair count of quarter-cycle pulses
  logic [3:0] qcnt_r;
  logic tach_lvl_r;
  logic [3:0] pole_pairs;
  assign pole_pairs = {1'b0, motor_cfg[PP_LSB +: 3]} + 4'd1;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      qcnt_r <= '0;
      tach_lvl_r <= 1'b1;
    end else if (!running) begin
      qcnt_r <= '0;
      tach_lvl_r <= 1'b1;
    end else if (comm_quarter) begin
      if (qcnt_r == pole_pairs - 4'd1) begin
        qcnt_r <= '0;
        tach_lvl_r <= !tach_lvl_r;
      end else begin
        qcnt_r <= qcnt_r + 4'd1;
      end
    end
  end

  logic fault_r, fault_cond;
  assign fault_cond = uv_s || ov_s && !(ov_hold && ov_inh) || tsd_s || puv_s;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) fault_r <= 1'b0;
    else if (fault_cond || evt || st_r == M_LATCHED) fault_r <= 1'b1;
    else if (st_r == M_START && open_loop_done) fault_r <= 1'b0;
  end

  assign status_w = {4'h0, short_s, puv_s, tsd_s, ov_s, uv_s, fault_r,
                     st_r == M_RUN, st_r == M_STANDBY, evt_cnt_r};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      applied_duty <= '0;
      startup_demand <= '0;
      slew_slow <= 1'b0;
      overvolt_level_sel <= 1'b0;
      supply_range_sel <= 1'b0;
      pump_enable <= 1'b1;
      vref_enable <= 1'b1;
      startup_ok_out <= 1'b0;
      startup_ok_oe <= 1'b1;
      fault_flag_low <= 1'b1;
      tach_out <= 1'b0;
      tach_oe <= 1'b0;
    end else begin
      startup_demand <= nvm[W_START_CFG][8:0];
      applied_duty <= (st_r == M_RUN) ? duty_lim[8:0] : 9'h000;
      slew_slow <= motor_cfg[SLEW_BIT];
      overvolt_level_sel <= prot_cfg[OVLVL_BIT];
      supply_range_sel <= prot_cfg[RANGE_BIT];
      pump_enable <= st_r != M_STANDBY;
      vref_enable <= st_r != M_STANDBY;
      startup_ok_out <= 1'b0;
      startup_ok_oe <= st_r != M_RUN;
      fault_flag_low <= !fault_r;
      tach_out <= 1'b0;
      tach_oe <= sda_low_r || (running && !tach_lvl_r);
    end
  end
endmodule

// *** bench/fan_host_model.sv ***
// host on the shared demand and tach pins
// the tach pin resolves through a pull-up; the host drives the demand pin both high and low
`timescale 1ns/1ns
module fan_host_model
  import fan_pkg::*;
(
  // clock and pins
  input wire logic mclk,
  input wire logic tach_oe,
  output logic scl,
  output logic sda
);
  logic sda_low = 1'b0;
  int nacks = 0;
  initial scl = 1'b1;
  assign sda = !(tach_oe || sda_low);
  task automatic hs(input logic a, input logic b);
    repeat (4) @(posedge mclk);
    sda_low <= a;
    repeat (4) @(posedge mclk);
    scl <= b;
  endtask
  task automatic demand(input logic lvl);
    @(posedge mclk);
    scl <= lvl;
  endtask
  // nine clocks a byte; the ninth carries the acknowledge
  task automatic xfer(input logic [7:0] d, input logic ma, input logic ea, output logic [7:0] q);
    logic [8:0] s;
    for (int i = 8; i >= 0; i--) begin
      hs(i > 0 ? !d[i - 1] : !ma, 1'b1);
      repeat (4) @(posedge mclk);
      s[i] = sda;
      repeat (4) @(posedge mclk);
      scl <= 1'b0;
    end
    q = s[8:1];
    if (ea && s[0]) nacks++;
  endtask
  // one word per frame, high byte first
  task automatic acc(input logic [4:0] w, input logic rd, inout logic [15:0] v);
    logic [7:0] q;
    hs(1'b0, 1'b1);
    hs(1'b1, 1'b0);
    xfer({DEV_ADDR_DEF, 1'b0}, 1'b1, 1'b1, q);
    xfer({3'h0, w}, 1'b1, 1'b1, q);
    if (rd) begin
      hs(1'b0, 1'b1);
      hs(1'b1, 1'b0);
      xfer({DEV_ADDR_DEF, 1'b1}, 1'b1, 1'b1, q);
    end
    xfer(rd ? 8'hff : v[15:8], !rd, !rd, q);
    if (rd) v[15:8] = q;
    xfer(rd ? 8'hff : v[7:0], 1'b1, !rd, q);
    if (rd) v[7:0] = q;
    hs(1'b1, 1'b1);
    hs(1'b0, 1'b1);
  endtask
endmodule

// *** bench/fan_drive_supervisor_sva.sv ***
// assertions on the fan drive supervisor ports
// bound into every instance of the design top
`timescale 1ns/1ns
module fan_sva (
  // watched ports
  input wire logic mclk,
  input wire logic rst,
  input wire logic thermal_trip,
  input wire logic current_limit,
  input wire logic rotor_lock,
  input wire logic drive_enable,
  input wire logic startup_req,
  input wire logic pwm_gate,
  input wire logic [8:0] applied_duty,
  input wire logic startup_ok_oe,
  input wire logic fault_flag_low
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  // two idle cycles absorb the registered lag behind drive_enable
  property p_req; startup_req |=> !startup_req; endproperty
  a_req: assert property (p_req) else $error("start request too long");
  property p_ok; !drive_enable [*2] |-> startup_ok_oe; endproperty
  a_ok: assert property (p_ok) else $error("ok pin released while off");
  property p_gate; !drive_enable [*2] |-> !pwm_gate; endproperty
  a_gate: assert property (p_gate) else $error("gate while disabled");
  property p_chop; current_limit [*6] |-> !pwm_gate; endproperty
  a_chop: assert property (p_chop) else $error("gate during limit");
  property p_duty; !drive_enable [*2] |-> applied_duty == 9'h000; endproperty
  a_duty: assert property (p_duty) else $error("duty while off");
  property p_fault; thermal_trip [*6] |-> !fault_flag_low; endproperty
  a_fault: assert property (p_fault) else $error("no fault when hot");
  property p_hot; thermal_trip [*6] |-> !drive_enable; endproperty
  a_hot: assert property (p_hot) else $error("drive when hot");
  property p_lock;
    rotor_lock && drive_enable && !startup_ok_oe |-> ##[1:2] !drive_enable ##1 !drive_enable [*8];
  endproperty
  a_lock: assert property (p_lock) else $error("no lockout");
  c_run: cover property (drive_enable && !startup_ok_oe);
  c_lock: cover property (rotor_lock && drive_enable);
  c_hot: cover property (thermal_trip && drive_enable);
endmodule
bind fan_drive_supervisor fan_sva fan_sva_i (.mclk, .rst, .thermal_trip, .current_limit,
  .rotor_lock, .drive_enable, .startup_req, .pwm_gate, .applied_duty, .startup_ok_oe,
  .fault_flag_low);

// *** bench/fan_drive_supervisor_test.sv ***
// self-checking bench for the fan drive supervisor
// host model owns the shared pins; the checker binds to the design
`timescale 1ns/1ns
module fan_drive_supervisor_test;
  import fan_pkg::*;
  // short lock tick keeps every lockout to a few thousand cycles
  localparam int LK = 64;
  localparam int TLK = int'(DEF_LOCK_TIME[15:8]) * LK;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] cmp = '0;
  logic [2:0] ev = '0;
  logic [8:0] adc_code = '0;
  logic pwm_raw = 1'b0;
  logic scl, sda, tach_out, tach_oe, pwm_gate, drive_enable, startup_req, slew_slow;
  logic ov_lvl, rng, pump_enable, vref_enable, ok_out, ok_oe, fault_flag_low, t;
  logic [8:0] applied_duty, startup_demand;
  logic [15:0] v, q;
  int seed = 32'h3582e5b8;
  int n_fail = 0;
  int compares = 0;
  int n, pp, adc_q;
  int mem [int];
  int wl [5] = '{9, 18, 19, 6, 5};
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    pwm_raw <= 1'($random(seed));
    adc_q <= adc_code;
    adc_code <= 9'($random(seed));
  end
  fan_drive_supervisor #(.LOCK_CYC(LK), .SAMPLE_CYC(4)) fan_drive_supervisor_i (
    .mclk, .rst, .speed_demand_in(scl), .tach_pin_in(sda), .tach_out, .tach_oe,
    .main_supply_uv(cmp[0]), .supply_over_protect_in(cmp[1]), .thermal_trip(cmp[2]),
    .pump_rail_uv(cmp[3]), .short_protect_in(cmp[4]), .current_limit(cmp[5]), .adc_code,
    .rotor_lock(ev[0]), .comm_quarter(ev[1]), .open_loop_done(ev[2]), .pwm_raw, .pwm_gate,
    .drive_enable, .startup_req, .applied_duty, .startup_demand, .slew_slow,
    .overvolt_level_sel(ov_lvl), .supply_range_sel(rng), .pump_enable, .vref_enable,
    .startup_ok_out(ok_out), .startup_ok_oe(ok_oe), .fault_flag_low);
  fan_host_model fan_host_model_i (.mclk, .tach_oe, .scl, .sda);
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic pulse(input int b);
    @(posedge mclk) ev[b] <= 1'b1;
    @(posedge mclk) ev[b] <= 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  task automatic run_up;
    n = 0;
    while (startup_req !== 1'b1 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    chk("start", 16'(n < 5000), 16'h0001);
    pulse(2);
    chk("ok", 16'(ok_oe), 16'h0000);
    chk("drive", 16'(drive_enable), 16'h0001);
    chk("fault", 16'(fault_flag_low), 16'h0001);
  endtask
  task automatic close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #300000;
    n_fail++;
    close_out;
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(negedge mclk);
    chk("fault", 16'(fault_flag_low), 16'h0001);
    chk("ok", 16'(ok_oe), 16'h0001);
    chk("od", 16'({tach_out, ok_out}), 16'h0000);
    foreach (wl[i]) begin
      v = 16'($random(seed));
      if (wl[i] == 18) v = DEF_MOTOR_CFG ^ (v & 16'h0400);
      if (wl[i] == 19) v = DEF_PROT_CFG | (v & 16'hc000);
      fan_host_model_i.acc(5'(wl[i]), 1'b0, v);
      mem[wl[i]] = (wl[i] == 5) ? 0 : int'(v);
      fan_host_model_i.acc(5'(wl[i]), 1'b1, q);
      chk("word", q, 16'(mem[wl[i]]));
    end
    chk("nack", 16'(fan_host_model_i.nacks), 16'h0000);
    chk("strt", 16'(startup_demand), 16'(mem[9] & 511));
    chk("slew", 16'(slew_slow), 16'(mem[18] >> SLEW_BIT & 1));
    chk("ovl", 16'(ov_lvl), 16'(mem[19] >> OVLVL_BIT & 1));
    chk("rng", 16'(rng), 16'(mem[19] >> RANGE_BIT & 1));
    $display("test config done");
    fan_host_model_i.demand(1'b0);
    // two demand windows may pass before the measured duty reads zero
    repeat (TLK + 4400) @(negedge mclk);
    chk("off", 16'(drive_enable), 16'h0000);
    chk("power", 16'({pump_enable, vref_enable}), 16'h0003);
    fan_host_model_i.demand(1'b1);
    run_up;
    t = tach_oe;
    pp = ((mem[18] >> PP_LSB) & 7) + 1;
    for (int i = 1; i <= 2 * pp; i++) begin
      pulse(1);
      chk("tach", 16'(tach_oe), 16'(t ^ 1'((i / pp) % 2)));
    end
    $display("test run done");
    pulse(0);
    chk("drive", 16'(drive_enable), 16'h0000);
    chk("fault", 16'(fault_flag_low), 16'h0000);
    run_up;
    chk("lock", 16'(n >= TLK - 8), 16'h0001);
    $display("test lock done");
    @(posedge mclk) cmp[2] <= 1'b1;
    repeat (TLK + 500) @(negedge mclk);
    chk("hot", 16'({drive_enable, fault_flag_low}), 16'h0000);
    @(posedge mclk) cmp[2] <= 1'b0;
    run_up;
    @(posedge mclk) cmp[5] <= 1'b1;
    repeat (6) @(negedge mclk);
    chk("chop", 16'(pwm_gate), 16'h0000);
    @(posedge mclk) cmp[5] <= 1'b0;
    cmp[4] <= 1'b1;
    repeat (SHORT_BLANK_CYC + 8) @(negedge mclk);
    chk("short", 16'(drive_enable), 16'h0000);
    @(posedge mclk) cmp[4] <= 1'b0;
    run_up;
    $display("test protect done");
    v = DEF_PROT_CFG ^ 16'h0001;
    fan_host_model_i.acc(W_PROT_CFG, 1'b0, v);
    fan_host_model_i.demand(1'b0);
    repeat (TLK + 4400) @(negedge mclk);
    chk("stby", 16'({pump_enable, vref_enable}), 16'h0000);
    fan_host_model_i.demand(1'b1);
    run_up;
    chk("wake", 16'({pump_enable, vref_enable}), 16'h0003);
    $display("test standby done");
    pp = $random(seed) & 15;
    v = 16'(pp);
    fan_host_model_i.acc(W_DUTY_CFG, 1'b0, v);
    v = DEF_MOTOR_CFG | 16'h0008;
    fan_host_model_i.acc(W_MOTOR_CFG, 1'b0, v);
    repeat (8) begin
      @(negedge mclk);
      n = (adc_q > 509) ? 511 : adc_q + 2;
      n = (n > 511 - 8 * pp) ? 511 - 8 * pp : n;
      chk("duty", 16'(applied_duty), 16'(n));
    end
    $display("test duty done");
    close_out;
  end
endmodule
